// ---- core/hbd_regs.svh ----
// Functional notes
// R01: Detection runs only while the enable bit is one; otherwise it stays idle.
// R02: Two-bit type result: 00 none, 01 no microphone, 11 with microphone.
// R03: Jack debounce codes 000-101 give 16-512 ms with 2-64 ms sampling.
// R04: Software never writes jack debounce codes 110 or 111.
// R05: Button debounce codes: 00 none, then 8, 16, 32 ms at 1, 2, 4 ms.
// R06: Button flag sets on a debounced press and clears when read.
// R07: Headset-present flag reads one while a headset is detected.
// R08: Coupling bit: zero capless drive, one ac-coupled drive.
// R09: Bit set means stereo fully differential output arrangement in use.
// R10: Bit set means stereo pseudodifferential output arrangement in use.
// R11: Software never sets both differential arrangement bits together.
// R12: Software writes zeros to the three low reserved bits; they read zero.
// R13: Results change only after stable samples across the whole debounce span.
`ifndef HBD_REGS_SVH
`define HBD_REGS_SVH

`define HBD_ADDR_DET_A    8'h0d
`define HBD_ADDR_DET_B    8'h0e

`define HBD_A_EN_BIT      7
`define HBD_A_TYPE_HI     6
`define HBD_A_TYPE_LO     5
`define HBD_A_JDEB_HI     4
`define HBD_A_JDEB_LO     2
`define HBD_A_BDEB_HI     1
`define HBD_A_BDEB_LO     0

`define HBD_B_AC_BIT      7
`define HBD_B_FDIFF_BIT   6
`define HBD_B_BTN_BIT     5
`define HBD_B_HS_BIT      4
`define HBD_B_PDIFF_BIT   3

`define HBD_RESET_VAL     8'h00

`define HBD_TYPE_NONE     2'h0
`define HBD_TYPE_NOMIC    2'h1
`define HBD_TYPE_MIC      2'h3

`define HBD_CLK_PERIOD_NS 20
`define HBD_SAMPLE_MS_NS  1000000
`define HBD_MS_CYCLES     (`HBD_SAMPLE_MS_NS / `HBD_CLK_PERIOD_NS)
`define HBD_DEB_SAMPLES   8

`endif

// ---- core/hbd_pkg.sv ----
package hbd_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hbd_bus_s;

  typedef struct packed {
    logic button;
    logic mic;
    logic jack;
  } hbd_sense_s;

  typedef struct packed {
    logic ac_coupled;
    logic fully_diff;
    logic pseudo_diff;
  } hbd_drv_s;

endpackage

// ---- core/hbd_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hbd_regs.svh"

module hbd_ctrl
  import hbd_pkg::*;
#(
  parameter int MS_CYCLES = `HBD_MS_CYCLES
) (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire hbd_bus_s   bus_i,
  input  wire hbd_sense_s sense_i,
  output logic [7:0]      rdata_o,
  output logic            rvalid_o,
  output logic [1:0]      headset_type_o,
  output logic            headset_present_o,
  output logic            button_flag_o,
  output hbd_drv_s        drv_cfg_o
);

  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);
  localparam logic [2:0]  DEB_LAST = 3'(`HBD_DEB_SAMPLES - 1);

  // Control, status and read-back fields
  logic       det_en_r, det_en_nxt;
  logic [2:0] jdeb_r, jdeb_nxt;
  logic [1:0] bdeb_r, bdeb_nxt;
  hbd_drv_s   drv_r, drv_nxt;
  logic       btn_flag_r, btn_flag_nxt;
  logic [1:0] type_r, type_nxt;
  logic       hs_r, hs_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       rvalid_r, rvalid_nxt;

  // Millisecond time base
  logic [15:0] pre_r, pre_nxt;
  logic [6:0]  ms_cnt_r, ms_cnt_nxt;
  logic        ms_pulse, jack_tick, btn_tick;
  logic [6:0]  jmask, bmask;

  logic [2:0] stab_r;
  logic       btn_prev_r, btn_prev_nxt;
  logic       press_evt;
  logic       wr_a, wr_b, rd_b;

  assign wr_a = bus_i.wr && bus_i.addr == `HBD_ADDR_DET_A;
  assign wr_b = bus_i.wr && bus_i.addr == `HBD_ADDR_DET_B;
  assign rd_b = bus_i.rd && bus_i.addr == `HBD_ADDR_DET_B;

  always_comb begin
    ms_pulse   = pre_r == MS_LAST;
    pre_nxt    = ms_pulse ? 16'h0000 : pre_r + 16'h0001;
    ms_cnt_nxt = ms_pulse ? ms_cnt_r + 7'h01 : ms_cnt_r;
    // Reserved jack codes sample every 128 ms, twice the code 101 spacing, rather than stalling
    jmask      = 7'((9'h002 << jdeb_r) - 9'h001); // R03
    bmask      = 7'((9'h001 << (bdeb_r - 2'h1)) - 9'h001); // R05
    jack_tick  = det_en_r && ms_pulse && (ms_cnt_r & jmask) == 7'h00; // R01
    btn_tick   = det_en_r && ms_pulse && (ms_cnt_r & bmask) == 7'h00;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pre_r    <= 16'h0000;
      ms_cnt_r <= 7'h00;
    end else begin
      pre_r    <= pre_nxt;
      ms_cnt_r <= ms_cnt_nxt;
    end
  end

  // Debounce per sensed line: jack and mic share the jack timing
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_deb
      logic       cand_r, cand_nxt;
      logic [2:0] cnt_r, cnt_nxt;
      logic       stab_nxt;
      logic       tick, bypass, raw;

      assign raw    = sense_i[g];
      assign tick   = (g == 2) ? btn_tick : jack_tick;
      assign bypass = (g == 2) && bdeb_r == 2'h0;

      always_comb begin
        cand_nxt = cand_r;
        cnt_nxt  = cnt_r;
        stab_nxt = stab_r[g];
        if (!det_en_r) begin
          cand_nxt = 1'b0; // R01
          cnt_nxt  = 3'h0;
          stab_nxt = 1'b0;
        end else if (bypass) begin
          stab_nxt = raw; // R05
        end else if (tick) begin
          if (raw != cand_r) begin
            cand_nxt = raw;
            cnt_nxt  = 3'h0; // R13
          end else if (cnt_r == DEB_LAST) begin
            stab_nxt = cand_r; // R13
          end else begin
            cnt_nxt = cnt_r + 3'h1;
          end
        end
      end

      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          cand_r    <= 1'b0;
          cnt_r     <= 3'h0;
          stab_r[g] <= 1'b0;
        end else begin
          cand_r    <= cand_nxt;
          cnt_r     <= cnt_nxt;
          stab_r[g] <= stab_nxt;
        end
      end
    end
  endgenerate

  assign press_evt = det_en_r && stab_r[2] && !btn_prev_r;

  always_comb begin
    det_en_nxt   = det_en_r;
    jdeb_nxt     = jdeb_r;
    bdeb_nxt     = bdeb_r;
    drv_nxt      = drv_r;
    btn_prev_nxt = stab_r[2];
    if (wr_a) begin
      det_en_nxt = bus_i.wdata[`HBD_A_EN_BIT];
      jdeb_nxt   = bus_i.wdata[`HBD_A_JDEB_HI:`HBD_A_JDEB_LO];
      bdeb_nxt   = bus_i.wdata[`HBD_A_BDEB_HI:`HBD_A_BDEB_LO];
    end
    if (wr_b) begin
      drv_nxt.ac_coupled  = bus_i.wdata[`HBD_B_AC_BIT]; // R08
      drv_nxt.fully_diff  = bus_i.wdata[`HBD_B_FDIFF_BIT]; // R09
      drv_nxt.pseudo_diff = bus_i.wdata[`HBD_B_PDIFF_BIT]; // R10
    end
    // Press in the reading cycle survives the clear
    btn_flag_nxt = press_evt ? 1'b1 : (rd_b ? 1'b0 : btn_flag_r); // R06
    hs_nxt       = det_en_r && stab_r[0]; // R07
    if (!det_en_r || !stab_r[0]) begin
      type_nxt = `HBD_TYPE_NONE; // R02
    end else if (stab_r[1]) begin
      type_nxt = `HBD_TYPE_MIC;
    end else begin
      type_nxt = `HBD_TYPE_NOMIC;
    end
    rvalid_nxt = bus_i.rd;
    rdata_nxt  = 8'h00;
    if (bus_i.rd && bus_i.addr == `HBD_ADDR_DET_A) begin
      rdata_nxt = {det_en_r, type_r, jdeb_r, bdeb_r};
    end else if (rd_b) begin
      rdata_nxt = {drv_r.ac_coupled, drv_r.fully_diff, btn_flag_r, hs_r,
                   drv_r.pseudo_diff, 3'h0}; // R12
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      det_en_r   <= 1'b0;
      jdeb_r     <= 3'h0;
      bdeb_r     <= 2'h0;
      drv_r      <= '0;
      btn_prev_r <= 1'b0;
      btn_flag_r <= 1'b0;
      hs_r       <= 1'b0;
      type_r     <= `HBD_TYPE_NONE;
      rvalid_r   <= 1'b0;
      rdata_r    <= `HBD_RESET_VAL;
    end else begin
      det_en_r   <= det_en_nxt;
      jdeb_r     <= jdeb_nxt;
      bdeb_r     <= bdeb_nxt;
      drv_r      <= drv_nxt;
      btn_prev_r <= btn_prev_nxt;
      btn_flag_r <= btn_flag_nxt;
      hs_r       <= hs_nxt;
      type_r     <= type_nxt;
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign rdata_o           = rdata_r;
  assign rvalid_o          = rvalid_r;
  assign headset_type_o    = type_r;
  assign headset_present_o = hs_r;
  assign button_flag_o     = btn_flag_r;
  assign drv_cfg_o         = drv_r;

  // Checking helper: ms pulses since the last jack sample
  logic [7:0] gap_r;
  logic       gap_ok_r;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_r    <= 8'h00;
      gap_ok_r <= 1'b0;
    end else begin
      gap_r    <= jack_tick ? 8'h00 : (ms_pulse ? gap_r + 8'h01 : gap_r);
      gap_ok_r <= wr_a ? 1'b0 : (jack_tick ? 1'b1 : gap_ok_r);
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_disabled_idle: assert property (!det_en_r |=> type_r == `HBD_TYPE_NONE && !hs_r) // R01
    else $error("Detection result while disabled");
  a_type_legal: assert property (type_r != 2'h2) // R02
    else $error("Reserved headset type reported");
  a_jack_period: assert property (jack_tick && gap_ok_r |-> gap_r == 8'((9'h002 << jdeb_r) - 9'h001)) // R03
    else $error("Jack sample spacing wrong");
  a_btn_bypass: assert property (det_en_r && bdeb_r == 2'h0 && $stable(det_en_r) |=> stab_r[2] == $past(sense_i.button)) // R05
    else $error("Undebounced button not followed");
  a_flag_set: assert property (press_evt |=> btn_flag_r ##1 (btn_flag_r || $past(rd_b))) // R06
    else $error("Button flag not set on press");
  a_flag_clear: assert property (rd_b && !press_evt |=> !btn_flag_r) // R06
    else $error("Button flag not cleared by read");
  a_present_type: assert property (hs_r == (type_r != `HBD_TYPE_NONE)) // R07
    else $error("Present flag disagrees with type");
  a_drv_write: assert property (wr_b |=> drv_r.ac_coupled == $past(bus_i.wdata[7]) && drv_r.fully_diff == $past(bus_i.wdata[6]) && drv_r.pseudo_diff == $past(bus_i.wdata[3])) // R08
    else $error("Driver configuration not stored");
  a_rsvd_zero: assert property (rd_b |=> rvalid_r && rdata_r[2:0] == 3'h0) // R12
    else $error("Reserved bits read nonzero");
  a_jack_stable: assert property (det_en_r && $past(det_en_r) && $changed(stab_r[0]) |-> $past(jack_tick)) // R13
    else $error("Jack state changed off a sample tick");

endmodule
`default_nettype wire

// ---- bench/hbd_jack_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module hbd_jack_model
  import hbd_pkg::*;
(
  input  wire logic   ref_clk_i,
  input  wire logic   plug_i,
  input  wire logic   mic_i,
  input  wire logic   press_i,
  input  wire logic   bounce_i,
  output var  hbd_sense_s sense_o
);
  logic [2:0] cnt_r;

  initial begin
    cnt_r   = 3'h0;
    sense_o = '0;
  end

  // Mod-5 chatter so that no sample rate sees a steady contact
  always @(posedge ref_clk_i) begin
    cnt_r          <= (cnt_r == 3'h4) ? 3'h0 : cnt_r + 3'h1;
    sense_o.jack   <= bounce_i ? (cnt_r < 3'h2) : plug_i;
    // Mic and button contacts exist only with the plug seated
    sense_o.mic    <= plug_i & mic_i;
    sense_o.button <= plug_i & press_i;
  end
endmodule

`default_nettype wire

// ---- bench/headset_button_detect_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hbd_regs.svh"

module headset_button_detect_ctrl_test
  import hbd_pkg::*;
;
  logic       ref_clk_i = 1'b0;
  logic       reset_i   = 1'b1;
  hbd_bus_s   bus       = '0;
  hbd_sense_s sense;
  logic       plug = 1'b0;
  logic       mic = 1'b0;
  logic       press = 1'b0;
  logic       bounce = 1'b0;
  logic [7:0] rdata;
  logic       rvalid;
  logic [1:0] htype;
  logic       hs;
  logic       btn;
  hbd_drv_s   drv;
  int         bad_count = 0;
  int         checked = 0;

  always #10 ref_clk_i = ~ref_clk_i;

  hbd_jack_model i_jack (.ref_clk_i(ref_clk_i), .plug_i(plug), .mic_i(mic),
    .press_i(press), .bounce_i(bounce), .sense_o(sense));

  hbd_ctrl #(.MS_CYCLES(4)) i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .bus_i(bus), .sense_i(sense), .rdata_o(rdata), .rvalid_o(rvalid),
    .headset_type_o(htype), .headset_present_o(hs), .button_flag_o(btn),
    .drv_cfg_o(drv));

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1 bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_i);
    #1 bus.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge ref_clk_i);
    #1 bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk_i);
    #1 bus.rd = 1'b0;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, want);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // Bounded poll on {type, button flag}
  task automatic wait_until(input logic [2:0] want);
    for (int n = 0; n < 500 && {htype, btn} !== want; n++) begin
      cycles(1);
    end
    check({5'h00, htype, btn}, {5'h00, want});
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    complete_run();
  end

  initial begin
    cycles(4);
    reset_i = 1'b0;
    rd(`HBD_ADDR_DET_A, 8'h00);
    rd(`HBD_ADDR_DET_B, 8'h00);
    wr(`HBD_ADDR_DET_B, 8'h88);
    rd(`HBD_ADDR_DET_B, 8'h88);
    check({5'h00, drv}, 8'h05);
    wr(`HBD_ADDR_DET_B, 8'h40);
    rd(`HBD_ADDR_DET_B, 8'h40);
    check({5'h00, drv}, 8'h02);
    rd(8'h33, 8'h00);
    $display("test registers done");
    plug = 1'b1;
    mic = 1'b1;
    cycles(200);
    check({6'h00, htype}, 8'h00);
    wr(`HBD_ADDR_DET_A, 8'h80);
    bounce = 1'b1;
    cycles(150);
    check({5'h00, htype, hs}, 8'h00);
    bounce = 1'b0;
    // Eight samples at 8 clocks each cannot finish in 40 clocks
    cycles(40);
    check({5'h00, htype, hs}, 8'h00);
    wait_until(3'b110);
    check({7'h00, hs}, 8'h01);
    rd(`HBD_ADDR_DET_A, 8'he0);
    rd(`HBD_ADDR_DET_B, 8'h50);
    $display("test jack done");
    press = 1'b1;
    wait_until(3'b111);
    press = 1'b0;
    rd(`HBD_ADDR_DET_B, 8'h70);
    rd(`HBD_ADDR_DET_B, 8'h50);
    wr(`HBD_ADDR_DET_A, 8'h81);
    cycles(20);
    press = 1'b1;
    cycles(20);
    check({7'h00, btn}, 8'h00);
    wait_until(3'b111);
    press = 1'b0;
    rd(`HBD_ADDR_DET_B, 8'h70);
    $display("test button done");
    // Let the release settle so the next press is a fresh edge
    cycles(60);
    check({7'h00, btn}, 8'h00);
    wr(`HBD_ADDR_DET_A, 8'h8b);
    press = 1'b1;
    // Nine button samples 16 clocks apart need over 100 clocks
    cycles(100);
    check({7'h00, btn}, 8'h00);
    wait_until(3'b111);
    press = 1'b0;
    rd(`HBD_ADDR_DET_B, 8'h70);
    mic = 1'b0;
    // Nine mic samples 32 clocks apart need over 200 clocks
    cycles(200);
    check({5'h00, htype, btn}, 8'h06);
    wait_until(3'b010);
    $display("test slow codes done");
    wr(`HBD_ADDR_DET_A, 8'h00);
    cycles(3);
    check({5'h00, htype, hs}, 8'h00);
    rd(`HBD_ADDR_DET_B, 8'h40);
    $display("test disable done");
    complete_run();
  end
endmodule

`default_nettype wire
